//--- rsts_pkg.sv
// Purpose: shared constants and types of the remote status, trigger and store core
// Assumes: setpoints are 16-bit codes, one stored location is one 64-bit word
// Notes: error codes are two's complement 16-bit values
package rsts_pkg;
	// stored locations
	localparam int RSTS_LOCS = 40;
	localparam int RSTS_DEPTH = 41;
	localparam int RSTS_AW = 6;
	localparam int RSTS_SP_W = 16;
	localparam int RSTS_WORD_W = 64;
	localparam logic [5:0] RSTS_CONT_ADDR = 6'h28;
	localparam logic [5:0] RSTS_LAST_ADDR = 6'h28;
	localparam logic [7:0] RSTS_LOC_MIN = 8'h01;
	localparam logic [7:0] RSTS_LOC_MAX = 8'h28;
	// reset values and CRC polynomial
	localparam logic [15:0] RSTS_SP_RESET = 16'h0000;
	localparam logic [7:0] RSTS_MASK_RESET = 8'h00;
	localparam logic [15:0] RSTS_CRC_INIT = 16'hffff;
	localparam logic [15:0] RSTS_CRC_POLY = 16'h1021;
	// status byte layout
	localparam int RSTS_BIT_OPER = 7;
	localparam int RSTS_BIT_SUM = 6;
	localparam int RSTS_BIT_ESB = 5;
	localparam int RSTS_BIT_MAV = 4;
	localparam int RSTS_BIT_QUES = 3;
	localparam int RSTS_BIT_ERRQ = 2;
	localparam logic [7:0] RSTS_MASK_FIXED = 8'h40;
	// parser, string and contrast limits
	localparam logic [4:0] RSTS_MAX_FRAC = 5'h08;
	localparam logic [31:0] RSTS_MAX_INT = 32'h17d78400;
	localparam logic [7:0] RSTS_MAX_STR = 8'hfd;
	localparam logic [7:0] RSTS_CONT_MAX = 8'h09;
	// error codes
	localparam logic [15:0] RSTS_ERR_SYNTAX = 16'hff88;
	localparam logic [15:0] RSTS_ERR_RANGE = 16'hff22;
	// response exponents and calibration shift
	localparam logic [7:0] RSTS_EXP_INT = 8'h00;
	localparam logic [7:0] RSTS_EXP_CONT = 8'hff;
	localparam logic [7:0] RSTS_EXP_SP = 8'hfd;
	localparam int RSTS_CAL_SHIFT = 15;
	// self test answers
	localparam logic [31:0] RSTS_TST_PASS = 32'h00000000;
	localparam logic [31:0] RSTS_TST_FAIL = 32'h00000001;
	// setpoint targets
	localparam logic [2:0] RSTS_T_VOLT = 3'h0;
	localparam logic [2:0] RSTS_T_CURR = 3'h1;
	localparam logic [2:0] RSTS_T_OVP = 3'h2;
	localparam logic [2:0] RSTS_T_OCP = 3'h3;
	localparam logic [2:0] RSTS_T_VTRIG = 3'h4;
	localparam logic [2:0] RSTS_T_CTRIG = 3'h5;

	typedef enum logic [3:0] {
		RSTS_OP_NOP = 4'h0,
		RSTS_OP_SAVE = 4'h1,
		RSTS_OP_RECALL = 4'h2,
		RSTS_OP_MASK_SET = 4'h3,
		RSTS_OP_MASK_Q = 4'h4,
		RSTS_OP_STB_Q = 4'h5,
		RSTS_OP_TRIG = 4'h6,
		RSTS_OP_TEST_Q = 4'h7,
		RSTS_OP_ABORT = 4'h8,
		RSTS_OP_INIT = 4'h9,
		RSTS_OP_INIT_CONT = 4'ha,
		RSTS_OP_CONT_SET = 4'hb,
		RSTS_OP_CONT_Q = 4'hc,
		RSTS_OP_NUM_SET = 4'hd,
		RSTS_OP_SP_Q = 4'he
	} rsts_op_e;

	typedef enum logic [2:0] {
		RSTS_S_IDLE = 3'b000,
		RSTS_S_RCL_RD = 3'b001,
		RSTS_S_RCL_LD = 3'b010,
		RSTS_S_CONT_RD = 3'b011,
		RSTS_S_CONT_LD = 3'b100,
		RSTS_S_SCAN_RD = 3'b101,
		RSTS_S_SCAN_ACC = 3'b110
	} rsts_state_e;
endpackage

//--- rsts_mem_if.sv
// Purpose: carrier between the core and its nonvolatile store
// Assumes: one write port and one registered read port
// Notes: none
`timescale 1ns/1ns
interface rsts_mem_if;
	logic we;
	logic [rsts_pkg::RSTS_AW-1:0] waddr;
	logic [rsts_pkg::RSTS_WORD_W-1:0] wdata;
	logic [rsts_pkg::RSTS_AW-1:0] raddr;
	logic [rsts_pkg::RSTS_WORD_W-1:0] rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- rsts_nvm.sv
// Purpose: stored setpoint locations and the contrast word
// Assumes: contents survive reset, as nonvolatile memory does
// Notes: read data come out of a register one edge after the address
`timescale 1ns/1ns
module rsts_nvm (
	// clock
	input wire logic ref_clk,
	// store port
	rsts_mem_if.mem bus
);
	import rsts_pkg::*;

	logic [RSTS_WORD_W-1:0] cells [RSTS_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (bus.we) begin
			cells[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		// write-through, so a scan that starts on a save sees the new word
		bus.rdata <= (bus.we && bus.waddr == bus.raddr) ? bus.wdata : cells[bus.raddr];
	end
endmodule // rsts_nvm

//--- rsts_core.sv
// Purpose: remote command core: store/recall, status byte, trigger, self test, contrast
// Assumes: commands arrive pre-parsed from bus logic on the same clock
// Notes: one command at a time, taken while cmd_ready is high
`timescale 1ns/1ns
module rsts_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire rsts_pkg::rsts_op_e cmd_op,
	input wire logic [7:0] cmd_arg,
	input wire logic [15:0] cmd_value,
	input wire logic [4:0] cmd_frac_digits,
	input wire logic [31:0] cmd_int_part,
	input wire logic cmd_syntax_bad,
	input wire logic cmd_range_bad,
	input wire logic [7:0] cmd_len,
	input wire logic cmd_listener,
	// calibration gain for answers
	input wire logic [15:0] cal_gain,
	// status sources
	input wire logic oper_summary,
	input wire logic event_summary,
	input wire logic msg_avail,
	input wire logic ques_summary,
	input wire logic error_queue_nonempty,
	// serial poll
	input wire logic spoll_req,
	output logic spoll_valid,
	output logic [7:0] spoll_byte,
	// answers
	output logic resp_valid,
	output logic [31:0] resp_mant,
	output logic [7:0] resp_exp,
	output logic err_valid,
	output logic [15:0] err_code,
	// status view
	output logic [7:0] status_summary_byte,
	output logic [7:0] service_request_mask,
	output logic service_flag,
	output logic wait_trig,
	// output setpoints
	output logic [15:0] volt_out,
	output logic [15:0] curr_out,
	output logic [15:0] ovp_out,
	output logic [15:0] ocp_out,
	output logic [15:0] volt_trig_out,
	output logic [15:0] curr_trig_out
);
	import rsts_pkg::*;

	rsts_mem_if mem_bus();

	rsts_nvm u_nvm (
		.ref_clk(ref_clk),
		.bus(mem_bus.mem)
	);

	rsts_state_e state;
	logic abort_pend;
	logic init_cont;
	logic sum_q;
	logic scan_check;
	logic [5:0] scan_idx;
	logic [5:0] rd_addr;
	logic [15:0] crc_acc;
	logic [15:0] crc_ref;
	logic [15:0] crc_fin;
	logic [7:0] stb_now;
	logic summary;
	logic take;
	logic parse_ok;
	logic loc_ok;
	logic cont_ok;
	logic scan_last;
	logic [5:0] loc_idx;
	logic [31:0] cal_prod;

	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [63:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 63; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ RSTS_CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] pick_sp(input logic [2:0] t, input logic [15:0] v,
			input logic [15:0] c, input logic [15:0] ov, input logic [15:0] oc,
			input logic [15:0] vt, input logic [15:0] ct);
		case (t)
			RSTS_T_VOLT: return v;
			RSTS_T_CURR: return c;
			RSTS_T_OVP: return ov;
			RSTS_T_OCP: return oc;
			RSTS_T_VTRIG: return vt;
			RSTS_T_CTRIG: return ct;
			default: return RSTS_SP_RESET;
		endcase
	endfunction

	// command acceptance and checks
	assign cmd_ready = (state == RSTS_S_IDLE) && !abort_pend;
	assign take = cmd_valid && cmd_ready && (cmd_len <= RSTS_MAX_STR);
	assign parse_ok = (cmd_frac_digits <= RSTS_MAX_FRAC) && (cmd_int_part <= RSTS_MAX_INT);
	assign loc_ok = (cmd_arg >= RSTS_LOC_MIN) && (cmd_arg <= RSTS_LOC_MAX);
	assign loc_idx = 6'(cmd_arg - RSTS_LOC_MIN);
	assign cont_ok = cmd_arg <= RSTS_CONT_MAX;
	assign scan_last = (scan_idx == RSTS_LAST_ADDR);
	assign crc_fin = crc_word(crc_acc, mem_bus.rdata);
	assign mem_bus.raddr = rd_addr;

	// status byte and summary, recomputed combinationally
	always_comb begin
		stb_now = 8'h00;
		stb_now[RSTS_BIT_OPER] = oper_summary;
		stb_now[RSTS_BIT_ESB] = event_summary;
		stb_now[RSTS_BIT_MAV] = msg_avail;
		stb_now[RSTS_BIT_QUES] = ques_summary;
		stb_now[RSTS_BIT_ERRQ] = error_queue_nonempty;
		summary = |(stb_now & service_request_mask);
		stb_now[RSTS_BIT_SUM] = summary;
	end

	// status byte view and mask
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_summary_byte <= 8'h00;
			service_request_mask <= RSTS_MASK_RESET;
		end else begin
			status_summary_byte <= stb_now;
			if (take && cmd_op == RSTS_OP_MASK_SET) begin
				service_request_mask <= cmd_arg & ~RSTS_MASK_FIXED;
			end
		end
	end

	// request flag: raised on a new reason, cleared by a poll, raise wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sum_q <= 1'b0;
			service_flag <= 1'b0;
			spoll_valid <= 1'b0;
			spoll_byte <= 8'h00;
		end else begin
			sum_q <= summary;
			spoll_valid <= spoll_req;
			if (spoll_req) begin
				spoll_byte <= {stb_now[7], service_flag, stb_now[5:0]};
			end
			if (summary && !sum_q) begin
				service_flag <= 1'b1;
			end else if (spoll_req) begin
				service_flag <= 1'b0;
			end
		end
	end

	// setpoints, trigger levels and arming
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			volt_out <= RSTS_SP_RESET;
			curr_out <= RSTS_SP_RESET;
			ovp_out <= RSTS_SP_RESET;
			ocp_out <= RSTS_SP_RESET;
			volt_trig_out <= RSTS_SP_RESET;
			curr_trig_out <= RSTS_SP_RESET;
			wait_trig <= 1'b0;
			init_cont <= 1'b0;
			abort_pend <= 1'b1;
		end else begin
			abort_pend <= 1'b0;
			if (abort_pend) begin
				volt_trig_out <= volt_out;
				curr_trig_out <= curr_out;
				wait_trig <= 1'b0;
			end else if (state == RSTS_S_RCL_LD) begin
				{volt_out, curr_out, ovp_out, ocp_out} <= mem_bus.rdata;
			end else if (take) begin
				case (cmd_op)
					RSTS_OP_NUM_SET: begin
						if (parse_ok && !cmd_syntax_bad && !cmd_range_bad) begin
							case (cmd_arg[2:0])
								RSTS_T_VOLT: volt_out <= cmd_value;
								RSTS_T_CURR: curr_out <= cmd_value;
								RSTS_T_OVP: ovp_out <= cmd_value;
								RSTS_T_OCP: ocp_out <= cmd_value;
								RSTS_T_VTRIG: volt_trig_out <= cmd_value;
								RSTS_T_CTRIG: curr_trig_out <= cmd_value;
								default: ;
							endcase
						end
					end
					RSTS_OP_TRIG: begin
						if (cmd_listener && wait_trig) begin
							volt_out <= volt_trig_out;
							curr_out <= curr_trig_out;
							wait_trig <= init_cont;
						end
					end
					RSTS_OP_ABORT: begin
						volt_trig_out <= volt_out;
						curr_trig_out <= curr_out;
						wait_trig <= 1'b0;
					end
					RSTS_OP_INIT: wait_trig <= 1'b1;
					RSTS_OP_INIT_CONT: begin
						init_cont <= cmd_arg[0];
						if (cmd_arg[0]) begin
							wait_trig <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// error log
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_valid <= 1'b0;
			err_code <= 16'h0000;
		end else begin
			err_valid <= 1'b0;
			if (take) begin
				if (cmd_op == RSTS_OP_NUM_SET && parse_ok && cmd_syntax_bad) begin
					err_valid <= 1'b1;
					err_code <= RSTS_ERR_SYNTAX;
				end else if ((cmd_op == RSTS_OP_NUM_SET && parse_ok && cmd_range_bad) ||
						((cmd_op == RSTS_OP_SAVE || cmd_op == RSTS_OP_RECALL) && !loc_ok) ||
						(cmd_op == RSTS_OP_CONT_SET && !cont_ok)) begin
					err_valid <= 1'b1;
					err_code <= RSTS_ERR_RANGE;
				end
			end
		end
	end

	// store writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mem_bus.we <= 1'b0;
			mem_bus.waddr <= 6'h00;
			mem_bus.wdata <= 64'h0;
		end else begin
			mem_bus.we <= 1'b0;
			if (take && cmd_op == RSTS_OP_SAVE && loc_ok) begin
				mem_bus.we <= 1'b1;
				mem_bus.waddr <= loc_idx;
				mem_bus.wdata <= {volt_out, curr_out, ovp_out, ocp_out};
			end else if (take && cmd_op == RSTS_OP_CONT_SET && cont_ok) begin
				mem_bus.we <= 1'b1;
				mem_bus.waddr <= RSTS_CONT_ADDR;
				mem_bus.wdata <= {56'h0, cmd_arg};
			end
		end
	end

	// sequencer for reads and memory scans
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= RSTS_S_IDLE;
			rd_addr <= 6'h00;
			scan_idx <= 6'h00;
			scan_check <= 1'b0;
			crc_acc <= RSTS_CRC_INIT;
			crc_ref <= RSTS_CRC_INIT;
		end else begin
			case (state)
				RSTS_S_IDLE: begin
					scan_idx <= 6'h00;
					crc_acc <= RSTS_CRC_INIT;
					if (abort_pend) begin
						rd_addr <= 6'h00;
						scan_check <= 1'b0;
						state <= RSTS_S_SCAN_RD;
					end else if (take) begin
						case (cmd_op)
							RSTS_OP_SAVE: begin
								if (loc_ok) begin
									rd_addr <= 6'h00;
									scan_check <= 1'b0;
									state <= RSTS_S_SCAN_RD;
								end
							end
							RSTS_OP_RECALL: begin
								if (loc_ok) begin
									rd_addr <= loc_idx;
									state <= RSTS_S_RCL_RD;
								end
							end
							RSTS_OP_CONT_Q: begin
								rd_addr <= RSTS_CONT_ADDR;
								state <= RSTS_S_CONT_RD;
							end
							RSTS_OP_TEST_Q: begin
								rd_addr <= 6'h00;
								scan_check <= 1'b1;
								state <= RSTS_S_SCAN_RD;
							end
							default: ;
						endcase
					end
				end
				RSTS_S_RCL_RD: state <= RSTS_S_RCL_LD;
				RSTS_S_RCL_LD: state <= RSTS_S_IDLE;
				RSTS_S_CONT_RD: state <= RSTS_S_CONT_LD;
				RSTS_S_CONT_LD: state <= RSTS_S_IDLE;
				RSTS_S_SCAN_RD: state <= RSTS_S_SCAN_ACC;
				RSTS_S_SCAN_ACC: begin
					crc_acc <= crc_fin;
					if (scan_last) begin
						if (!scan_check) begin
							crc_ref <= crc_fin;
						end
						state <= RSTS_S_IDLE;
					end else begin
						scan_idx <= scan_idx + 6'h01;
						rd_addr <= scan_idx + 6'h01;
						state <= RSTS_S_SCAN_RD;
					end
				end
				default: state <= RSTS_S_IDLE;
			endcase
		end
	end

	// calibrated setpoint for numeric answers
	assign cal_prod = pick_sp(cmd_arg[2:0], volt_out, curr_out, ovp_out, ocp_out,
		volt_trig_out, curr_trig_out) * cal_gain;

	// query answers, all as mantissa and exponent
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_mant <= 32'h0;
			resp_exp <= RSTS_EXP_INT;
		end else begin
			resp_valid <= 1'b0;
			if (state == RSTS_S_CONT_LD) begin
				resp_valid <= 1'b1;
				resp_mant <= {28'h0, mem_bus.rdata[3:0]};
				resp_exp <= RSTS_EXP_CONT;
			end else if (state == RSTS_S_SCAN_ACC && scan_last && scan_check) begin
				resp_valid <= 1'b1;
				resp_mant <= (crc_fin == crc_ref) ? RSTS_TST_PASS : RSTS_TST_FAIL;
				resp_exp <= RSTS_EXP_INT;
			end else if (take) begin
				case (cmd_op)
					RSTS_OP_MASK_Q: begin
						resp_valid <= 1'b1;
						resp_mant <= {24'h0, service_request_mask};
						resp_exp <= RSTS_EXP_INT;
					end
					RSTS_OP_STB_Q: begin
						resp_valid <= 1'b1;
						resp_mant <= {24'h0, stb_now};
						resp_exp <= RSTS_EXP_INT;
					end
					RSTS_OP_SP_Q: begin
						resp_valid <= 1'b1;
						resp_mant <= {15'h0, cal_prod[31:RSTS_CAL_SHIFT]};
						resp_exp <= RSTS_EXP_SP;
					end
					default: ;
				endcase
			end
		end
	end
endmodule // rsts_core

//--- rsts_core_chk.sv
// Purpose: port-level checks of the command core
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every rsts_core
`timescale 1ns/1ns
module rsts_core_chk
	import rsts_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// command port
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire rsts_pkg::rsts_op_e cmd_op,
	input wire logic [7:0] cmd_arg,
	input wire logic [4:0] cmd_frac_digits,
	input wire logic cmd_syntax_bad,
	input wire logic cmd_range_bad,
	input wire logic [7:0] cmd_len,
	input wire logic cmd_listener,
	// status sources
	input wire logic oper_summary,
	input wire logic event_summary,
	input wire logic msg_avail,
	input wire logic ques_summary,
	input wire logic error_queue_nonempty,
	// serial poll
	input wire logic spoll_req,
	input wire logic spoll_valid,
	input wire logic [7:0] spoll_byte,
	// answers and state
	input wire logic resp_valid,
	input wire logic [31:0] resp_mant,
	input wire logic [7:0] resp_exp,
	input wire logic err_valid,
	input wire logic [15:0] err_code,
	input wire logic [7:0] status_summary_byte,
	input wire logic [7:0] service_request_mask,
	input wire logic service_flag,
	input wire logic wait_trig,
	input wire logic [15:0] volt_out,
	input wire logic [15:0] curr_out,
	input wire logic [15:0] volt_trig_out,
	input wire logic [15:0] curr_trig_out
);
	logic take;
	logic [7:0] src;
	assign take = cmd_valid && cmd_ready && cmd_len <= RSTS_MAX_STR;
	assign src = {oper_summary, 1'b0, event_summary, msg_avail, ques_summary,
		error_queue_nonempty, 2'b00};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_mask_bit_fixed: assert property (service_request_mask[6] == 1'b0)
		else $error("mask bit 6 set");
	a_status_layout: assert property (!$past(rst) |-> (status_summary_byte & 8'hbf) == $past(src))
		else $error("status byte layout wrong");
	a_summary_or: assert property ($stable(src) && $stable(service_request_mask) |=>
		status_summary_byte[6] == |(status_summary_byte & $past(service_request_mask) & 8'hbf))
		else $error("summary bit wrong");
	a_spoll_answer: assert property (spoll_req |=> spoll_valid && spoll_byte[6] == $past(service_flag))
		else $error("serial poll answer wrong");
	a_spoll_clear: assert property (spoll_req && $stable(status_summary_byte[6]) ##1
		$stable(status_summary_byte[6]) |-> !service_flag)
		else $error("request flag not cleared");
	a_stb_answer: assert property (take && cmd_op == RSTS_OP_STB_Q && $stable(src)
		&& $stable(service_request_mask) |=> resp_valid && resp_exp == RSTS_EXP_INT
		&& resp_mant == {24'h0, $past(status_summary_byte)})
		else $error("status query answer wrong");
	a_mask_answer: assert property (take && cmd_op == RSTS_OP_MASK_Q |=>
		resp_valid && resp_mant == {24'h0, $past(service_request_mask)})
		else $error("mask query answer wrong");
	a_trig_apply: assert property (take && cmd_op == RSTS_OP_TRIG && cmd_listener && wait_trig |=>
		volt_out == $past(volt_trig_out) && curr_out == $past(curr_trig_out))
		else $error("trigger levels not applied");
	a_trig_ignore: assert property (take && cmd_op == RSTS_OP_TRIG && !cmd_listener |=>
		$stable(volt_out) && $stable(curr_out))
		else $error("trigger acted while not listener");
	a_abort_levels: assert property (take && cmd_op == RSTS_OP_ABORT |=>
		volt_trig_out == volt_out && curr_trig_out == curr_out && !wait_trig)
		else $error("abort did not cancel levels");
	a_drop_quiet: assert property (take && cmd_op == RSTS_OP_NUM_SET && cmd_frac_digits > RSTS_MAX_FRAC
		&& !cmd_syntax_bad && !cmd_range_bad |=> !err_valid)
		else $error("dropped value raised error");
	a_cont_range: assert property (take && cmd_op == RSTS_OP_CONT_SET && cmd_arg > RSTS_CONT_MAX
		&& !cmd_syntax_bad |=> err_valid && err_code == RSTS_ERR_RANGE)
		else $error("contrast range error missing");
endmodule // rsts_core_chk

bind rsts_core rsts_core_chk u_chk (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_arg,
	.cmd_frac_digits, .cmd_syntax_bad, .cmd_range_bad, .cmd_len, .cmd_listener, .oper_summary,
	.event_summary, .msg_avail, .ques_summary, .error_queue_nonempty, .spoll_req, .spoll_valid,
	.spoll_byte, .resp_valid, .resp_mant, .resp_exp, .err_valid, .err_code, .status_summary_byte,
	.service_request_mask, .service_flag, .wait_trig, .volt_out, .curr_out, .volt_trig_out,
	.curr_trig_out);

//--- rsts_host.sv
// Purpose: remote host model issuing pre-parsed commands
// Assumes: commands held until taken on valid and ready
// Notes: parser fields are set by the bench between commands
`timescale 1ns/1ns
module rsts_host
	import rsts_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// command port
	input wire logic cmd_ready,
	output logic cmd_valid,
	output rsts_pkg::rsts_op_e cmd_op,
	output logic [7:0] cmd_arg,
	output logic [15:0] cmd_value,
	output logic [4:0] cmd_frac_digits,
	output logic [31:0] cmd_int_part,
	output logic cmd_syntax_bad,
	output logic cmd_range_bad,
	output logic [7:0] cmd_len,
	output logic cmd_listener
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = RSTS_OP_NOP;
		cmd_arg = 8'h00;
		cmd_value = 16'h0000;
		cmd_frac_digits = 5'h00;
		cmd_int_part = 32'h00000000;
		cmd_syntax_bad = 1'b0;
		cmd_range_bad = 1'b0;
		cmd_len = 8'h10;
		cmd_listener = 1'b1;
	end

	// one command, held until the taking edge; mask bit 6 is never relied on
	task automatic issue(input rsts_op_e op, input logic [7:0] arg, input logic [15:0] val,
			output bit late);
		int n;
		n = 0;
		@(posedge ref_clk);
		#2;
		cmd_op = op;
		cmd_arg = arg;
		cmd_value = val;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		late = (n >= 400);
		@(posedge ref_clk);
		#2;
		cmd_valid = 1'b0;
	endtask
endmodule // rsts_host

//--- remote_status_trigger_store_tb.sv
// Purpose: self-checking bench of the command core
// Assumes: host model drives the command port
// Notes: random values from a fixed seed
`timescale 1ns/1ns
module remote_status_trigger_store_tb;
	import rsts_pkg::*;
	logic ref_clk, rst, spoll_req;
	logic [15:0] cal_gain;
	logic [4:0] src;
	logic cmd_valid, cmd_ready, cmd_syntax_bad, cmd_range_bad, cmd_listener;
	rsts_op_e cmd_op;
	logic [7:0] cmd_arg, cmd_len, spoll_byte, resp_exp, status_summary_byte, service_request_mask;
	logic [15:0] cmd_value, err_code, volt_out, curr_out, ovp_out, ocp_out;
	logic [15:0] volt_trig_out, curr_trig_out;
	logic [4:0] cmd_frac_digits;
	logic [31:0] cmd_int_part, resp_mant;
	logic spoll_valid, resp_valid, err_valid, service_flag, wait_trig;
	int bad_count = 0;
	int n_compared = 0;

	rsts_core u_dut (.*, .oper_summary(src[4]), .event_summary(src[3]), .msg_avail(src[2]),
		.ques_summary(src[1]), .error_queue_nonempty(src[0]));
	rsts_host u_host (.*);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [7:0] exp_stb(input logic [4:0] s, input logic [7:0] m);
		logic [7:0] b;
		b = {s[4], 1'b0, s[3:0], 2'b00};
		b[6] = |(b & m & 8'hbf);
		return b;
	endfunction

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic close_out();
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask

	task automatic wait_resp(input int lim);
		int n;
		n = 0;
		while (resp_valid !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
		if (n >= lim) bad_count++;
	endtask

	task automatic send(input rsts_op_e op, input logic [7:0] arg, input logic [15:0] val);
		bit late;
		u_host.issue(op, arg, val, late);
		if (late) bad_count++;
	endtask

	initial begin
		#(50 * 40000);
		bad_count++;
		close_out();
	end

	initial begin
		logic [15:0] sp [4];
		logic [7:0] m, loc;
		void'($urandom(32'h768f));
		rst = 1'b1;
		spoll_req = 1'b0;
		src = 5'h00;
		cal_gain = 16'($urandom);
		step(5);
		rst = 1'b0;
		step(1);
		chk("armed", wait_trig, 0);
		chk("vtrig", volt_trig_out, RSTS_SP_RESET);
		for (int i = 0; i < 12; i++) begin
			m = (i == 0) ? 8'hff : (i == 1) ? 8'h40 : 8'($urandom);
			src = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
			send(RSTS_OP_MASK_SET, m, 16'h0000);
			send(RSTS_OP_MASK_Q, 8'h00, 16'h0000);
			chk("mask", resp_mant, {24'h0, m & 8'hbf});
			send(RSTS_OP_STB_Q, 8'h00, 16'h0000);
			chk("stb", resp_mant, {24'h0, exp_stb(src, m)});
			send(RSTS_OP_STB_Q, 8'h00, 16'h0000);
			chk("stb again", resp_mant, {24'h0, exp_stb(src, m)});
		end
		send(RSTS_OP_MASK_SET, 8'h10, 16'h0000);
		src = 5'h00;
		step(3);
		src = 5'h04;
		step(3);
		for (int i = 0; i < 2; i++) begin
			spoll_req = 1'b1;
			step(1);
			spoll_req = 1'b0;
			chk("poll", {spoll_valid, spoll_byte}, (i == 0) ? 9'h150 : 9'h110);
			chk("flag", service_flag, 0);
			chk("sum", status_summary_byte, 8'h50);
			step(1);
		end
		// every word of the store is given a value so that the CRC is defined
		send(RSTS_OP_CONT_SET, 8'h00, 16'h0000);
		for (int k = 1; k <= 40; k++) send(RSTS_OP_SAVE, 8'(k), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			loc = (i == 0) ? 8'd1 : (i == 1) ? 8'd40 : 8'($urandom_range(39, 2));
			for (int k = 0; k < 4; k++) begin
				sp[k] = 16'($urandom);
				send(RSTS_OP_NUM_SET, 8'(k), sp[k]);
			end
			send(RSTS_OP_SAVE, loc, 16'h0000);
			for (int k = 0; k < 4; k++) send(RSTS_OP_NUM_SET, 8'(k), ~sp[k]);
			send(RSTS_OP_RECALL, loc, 16'h0000);
			step(3);
			chk("setpoints", {volt_out, curr_out}, {sp[0], sp[1]});
			chk("limits", {ovp_out, ocp_out}, {sp[2], sp[3]});
		end
		send(RSTS_OP_TEST_Q, 8'h00, 16'h0000);
		wait_resp(300);
		chk("test", resp_mant, RSTS_TST_PASS);
		for (int i = 0; i < 2; i++) begin
			send(RSTS_OP_SAVE, (i == 0) ? 8'd0 : 8'd41, 16'h0000);
			chk("loc err", {err_valid, err_code}, {1'b1, RSTS_ERR_RANGE});
		end
		send(RSTS_OP_SP_Q, 8'h00, 16'h0000);
		chk("sp answer", resp_mant, ({16'h0, sp[0]} * {16'h0, cal_gain}) >> 15);
		chk("sp exp", resp_exp, RSTS_EXP_SP);
		send(RSTS_OP_NUM_SET, RSTS_T_VTRIG, 16'h0abc);
		send(RSTS_OP_NUM_SET, RSTS_T_CTRIG, 16'h0def);
		send(RSTS_OP_INIT, 8'h00, 16'h0000);
		u_host.cmd_listener = 1'b0;
		send(RSTS_OP_TRIG, 8'h00, 16'h0000);
		chk("no trig", {wait_trig, volt_out, curr_out}, {1'b1, sp[0], sp[1]});
		u_host.cmd_listener = 1'b1;
		send(RSTS_OP_TRIG, 8'h00, 16'h0000);
		chk("trig", {wait_trig, volt_out, curr_out}, {1'b0, 32'h0abc0def});
		send(RSTS_OP_INIT_CONT, 8'h01, 16'h0000);
		send(RSTS_OP_TRIG, 8'h00, 16'h0000);
		chk("rearm", {wait_trig, volt_out, curr_out}, {1'b1, 32'h0abc0def});
		send(RSTS_OP_NUM_SET, RSTS_T_VTRIG, 16'h0123);
		send(RSTS_OP_ABORT, 8'h00, 16'h0000);
		chk("abort", {wait_trig, volt_trig_out, curr_trig_out}, {1'b0, 32'h0abc0def});
		u_host.cmd_frac_digits = 5'd9;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h1234);
		chk("frac drop", {err_valid, volt_out}, {1'b0, 16'h0abc});
		u_host.cmd_frac_digits = 5'd8;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h1234);
		chk("frac ok", volt_out, 16'h1234);
		u_host.cmd_frac_digits = 5'd0;
		u_host.cmd_int_part = RSTS_MAX_INT + 32'h1;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h5678);
		chk("int drop", {err_valid, volt_out}, {1'b0, 16'h1234});
		u_host.cmd_int_part = RSTS_MAX_INT;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h5678);
		chk("int ok", volt_out, 16'h5678);
		u_host.cmd_len = 8'd254;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h9abc);
		chk("long drop", {err_valid, volt_out}, {1'b0, 16'h5678});
		u_host.cmd_len = 8'd253;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h9abc);
		chk("long ok", volt_out, 16'h9abc);
		u_host.cmd_syntax_bad = 1'b1;
		u_host.cmd_range_bad = 1'b1;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h0001);
		chk("syntax", {err_valid, err_code}, {1'b1, RSTS_ERR_SYNTAX});
		u_host.cmd_syntax_bad = 1'b0;
		send(RSTS_OP_NUM_SET, 8'h00, 16'h0001);
		chk("range", {err_valid, err_code}, {1'b1, RSTS_ERR_RANGE});
		u_host.cmd_range_bad = 1'b0;
		for (int k = 0; k < 11; k++) begin
			send(RSTS_OP_CONT_SET, 8'(k), 16'h0000);
			if (k == 10) begin
				chk("cont err", {err_valid, err_code}, {1'b1, RSTS_ERR_RANGE});
			end else begin
				send(RSTS_OP_CONT_Q, 8'h00, 16'h0000);
				wait_resp(10);
				chk("contrast", {resp_exp, resp_mant}, {RSTS_EXP_CONT, 32'(k)});
			end
		end
		send(RSTS_OP_TEST_Q, 8'h00, 16'h0000);
		wait_resp(300);
		chk("test fail", resp_mant, RSTS_TST_FAIL);
		// reset in mid-run: abort again, contrast kept in the store
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		chk("armed again", {wait_trig, volt_trig_out}, {1'b0, RSTS_SP_RESET});
		send(RSTS_OP_CONT_Q, 8'h00, 16'h0000);
		wait_resp(10);
		chk("contrast kept", {resp_exp, resp_mant}, {RSTS_EXP_CONT, 32'h9});
		close_out();
	end
endmodule // remote_status_trigger_store_tb
